// File: design/usbf_pkg.sv
// Shared constants and types for the endpoint buffer and host configuration block.
package usbf_pkg;
  // ============================================================
  // Sizes.
  localparam int NUM_ENT   = 8;
  localparam int EW        = 3;
  localparam int RAM_AW    = 10;
  localparam int RAM_BYTES = 1024;
  localparam int CW        = 12;
  localparam int MPW       = 11;
  localparam int FNW       = 11;
  localparam int IVW       = 5;
  localparam int TCW       = 16;
  // ============================================================
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_BUF    = 8'h08;
  localparam logic [7:0] OFF_HOST   = 8'h0C;
  localparam logic [7:0] OFF_MAXP   = 8'h10;
  localparam logic [7:0] OFF_IVAL   = 8'h14;
  localparam logic [7:0] OFF_CMD    = 8'h18;
  localparam logic [7:0] OFF_DATA   = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_FRAME  = 8'h24;
  // ============================================================
  // Field positions.
  localparam int CTRL_HOST     = 0;
  localparam int BUF_CODE_LSB  = 16;
  localparam int CMD_FLUSH     = 0;
  localparam int CMD_SEND      = 1;
  localparam int CMD_ACK       = 2;
  localparam int CMD_CLR_READY = 3;
  localparam int CMD_CLR_ERR   = 4;
  localparam int CMD_REQ_IN    = 5;
  localparam int ST_READY      = 16;
  localparam int ST_PEND       = 17;
  localparam int ST_TOUT       = 18;
  localparam int ST_REFUSED    = 19;
  // ============================================================
  // Fixed values and reset values.
  localparam logic              DIR_TX            = 1'b1;
  localparam logic              host_transmit_dir = 1'b1;
  localparam logic              host_receive_dir  = 1'b0;
  localparam logic [CW-1:0]     EP0_BYTES         = 12'h040;
  localparam logic [RAM_AW-1:0] EP0_TX_START      = 10'h000;
  localparam logic [RAM_AW-1:0] EP0_RX_START      = 10'h040;
  localparam logic [CW-1:0]     SIZE_UNIT         = 12'h008;
  localparam logic [3:0]        size_sixteen_double = 4'h9;
  localparam logic [IVW-1:0]    MAX_NAK_LIMIT     = 5'h10;
  localparam logic [IVW-1:0]    DISABLE_NAK_LIMIT = 5'h00;
  localparam logic [RAM_AW-1:0] START_RST         = 10'h000;
  localparam logic [3:0]        CODE_RST          = 4'h0;
  localparam logic [MPW-1:0]    MAXP_RST          = 11'h008;
  localparam logic [IVW-1:0]    IVAL_RST          = 5'h00;
  // ============================================================
  // Types.
  typedef enum logic [1:0] {
    type_control     = 2'h0,
    type_isochronous = 2'h1,
    type_bulk        = 2'h2,
    type_interrupt   = 2'h3
  } usbf_xfer_t;
  typedef enum logic [1:0] {
    dma_off        = 2'h0,
    dma_per_byte   = 2'h1,
    dma_per_packet = 2'h2,
    dma_spare      = 2'h3
  } usbf_dma_t;
  typedef struct packed {
    logic       auto_ready_flag_clear;
    logic       auto_in_token_request;
    logic       auto_send_on_full_payload;
    usbf_dma_t  dma_request_style;
    usbf_xfer_t xfer;
    logic       speed_sel_low;
    logic [3:0] remote_endpoint_number;
    logic [6:0] func_addr;
  } usbf_hcfg_t;
  typedef struct packed {
    logic           rx_wr;
    logic           rx_pkt_end;
    logic [EW-1:0]  rx_entry;
    logic [7:0]     rx_data;
    logic           tx_rd;
    logic           tx_done;
    logic [EW-1:0]  tx_entry;
    logic           nak;
    logic [EW-1:0]  nak_entry;
    logic           sof;
    logic [FNW-1:0] frame;
  } usbf_link_t;
  typedef struct packed {
    logic          valid;
    logic          is_in;
    logic [6:0]    func_addr;
    logic [3:0]    remote_ep;
    logic          low_speed;
    logic [EW-1:0] entry;
  } usbf_token_t;
endpackage

// File: design/usbf_ep_timer.sv
// Per-entry frame timer giving a NAK timeout or a polling pulse.
module usbf_ep_timer
  import usbf_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           sof,
  input  wire logic           nak,
  input  wire logic           clr,
  input  wire logic           is_ep0,
  input  wire usbf_xfer_t     xfer,
  input  wire logic [IVW-1:0] interval,
  output logic                poll,
  output logic                timeout
);
  logic           nak_mode;
  logic [IVW-1:0] n_eff;
  logic [TCW-1:0] limit;
  logic           hit;
  logic [TCW-1:0] cnt_reg;
  logic           active_reg;

  // ============================================================
  // Period selection.
  always_comb begin
    nak_mode = is_ep0 || xfer == type_control || xfer == type_bulk;
    n_eff    = (interval > MAX_NAK_LIMIT) ? MAX_NAK_LIMIT : interval;
    if (!nak_mode && xfer == type_interrupt) begin
      limit = TCW'(interval);
    end else begin
      limit = TCW'(1) << (n_eff - IVW'(1));
    end
    hit = sof && interval != DISABLE_NAK_LIMIT && (cnt_reg + TCW'(1) >= limit);
  end

  // ============================================================
  // Frame counting.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
      poll       <= 1'b0;
      timeout    <= 1'b0;
    end else begin
      poll    <= 1'b0;
      timeout <= 1'b0;
      if (clr) begin
        cnt_reg    <= '0;
        active_reg <= 1'b0;
      end else if (nak_mode) begin
        if (nak) begin
          active_reg <= 1'b1;
        end
        if (active_reg && hit) begin
          timeout    <= 1'b1;
          cnt_reg    <= '0;
          active_reg <= 1'b0;
        end else if (active_reg && sof) begin
          cnt_reg <= cnt_reg + TCW'(1);
        end
      end else if (hit) begin
        poll    <= 1'b1;
        cnt_reg <= '0;
      end else if (sof && interval != '0) begin
        cnt_reg <= cnt_reg + TCW'(1);
      end
    end
  end
endmodule

// File: design/usbf_endpoint_buf.sv
// Endpoint buffer allocation, flush, frame number and host endpoint configuration.
module usbf_endpoint_buf
  import usbf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  output logic [31:0]       rdata,
  input  wire usbf_link_t   link,
  output logic [7:0]        tx_data,
  output usbf_token_t       token,
  output logic [NUM_ENT-1:0] tx_pending,
  output logic [NUM_ENT-1:0] rx_ready,
  output logic [NUM_ENT-1:0] dma_req,
  output logic              host_mode
);
  logic [7:0]          mem       [RAM_BYTES];
  logic [RAM_AW-1:0]   start_reg [NUM_ENT];
  logic [3:0]          code_reg  [NUM_ENT];
  usbf_hcfg_t          hcfg_reg  [NUM_ENT];
  logic [MPW-1:0]      maxp_reg  [NUM_ENT];
  logic [IVW-1:0]      ival_reg  [NUM_ENT];
  logic [CW-1:0]       cnt_reg   [NUM_ENT];
  logic [CW-1:0]       wptr_reg  [NUM_ENT];
  logic [CW-1:0]       rptr_reg  [NUM_ENT];
  logic [RAM_AW-1:0]   start_of  [NUM_ENT];
  logic [CW-1:0]       size_of   [NUM_ENT];
  logic [NUM_ENT-1:0]  ready_reg;
  logic [NUM_ENT-1:0]  pend_reg;
  logic [NUM_ENT-1:0]  tout_reg;
  logic [NUM_ENT-1:0]  refused_reg;
  logic [NUM_ENT-1:0]  req_reg;
  logic [NUM_ENT-1:0]  due_reg;
  logic [NUM_ENT-1:0]  hit_sel;
  logic [NUM_ENT-1:0]  inc_vec;
  logic [NUM_ENT-1:0]  dec_vec;
  logic [NUM_ENT-1:0]  clr_vec;
  logic [NUM_ENT-1:0]  done_vec;
  logic [NUM_ENT-1:0]  tok_vec;
  logic [NUM_ENT-1:0]  want;
  logic [NUM_ENT-1:0]  poll;
  logic [NUM_ENT-1:0]  tmo;
  logic [NUM_ENT-1:0]  pend_set;
  logic [NUM_ENT-1:0]  ready_clr;
  logic [NUM_ENT-1:0]  dma_next;
  logic [EW-1:0]       sel_reg;
  logic [EW-1:0]       scan_reg;
  logic [FNW-1:0]      frame_reg;
  logic                sel_tx;
  logic                wr_cmd;
  logic                flush_cmd;
  logic                ack_cmd;
  logic                sw_push;
  logic                sw_pop;
  logic                lk_push;
  logic                lk_pop;
  logic [RAM_AW-1:0]   sw_addr;
  logic [RAM_AW-1:0]   lk_wr_addr;
  logic [RAM_AW-1:0]   lk_rd_addr;

  // ============================================================
  // Address inside an endpoint region.
  function automatic logic [RAM_AW-1:0] buf_addr(input logic [RAM_AW-1:0] start,
                                                 input logic [CW-1:0]     size,
                                                 input logic [CW-1:0]     ptr);
    buf_addr = start + RAM_AW'(ptr & (size - CW'(1)));
  endfunction

  // ============================================================
  // Access decode.
  assign sel_tx    = sel_reg[0];
  assign wr_cmd    = wr_en && addr == OFF_CMD;
  assign flush_cmd = wr_cmd && wdata[CMD_FLUSH];
  assign ack_cmd   = wr_cmd && wdata[CMD_ACK] && host_mode && !sel_tx;
  assign sw_push   = wr_en && addr == OFF_DATA && sel_tx && !pend_reg[sel_reg]
                     && cnt_reg[sel_reg] < size_of[sel_reg];
  assign sw_pop    = rd_en && addr == OFF_DATA && !sel_tx && cnt_reg[sel_reg] != '0;
  assign lk_push   = link.rx_wr && !link.rx_entry[0]
                     && cnt_reg[link.rx_entry] < size_of[link.rx_entry];
  assign lk_pop    = link.tx_rd && link.tx_entry[0] && cnt_reg[link.tx_entry] != '0;
  assign sw_addr    = sel_tx ? buf_addr(start_of[sel_reg], size_of[sel_reg], wptr_reg[sel_reg])
                             : buf_addr(start_of[sel_reg], size_of[sel_reg], rptr_reg[sel_reg]);
  assign lk_wr_addr = buf_addr(start_of[link.rx_entry], size_of[link.rx_entry],
                               wptr_reg[link.rx_entry]);
  assign lk_rd_addr = buf_addr(start_of[link.tx_entry], size_of[link.tx_entry],
                               rptr_reg[link.tx_entry]);

  // ============================================================
  // Per-entry decode, timers and request logic.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENT; gi++) begin : g_ent
      if (gi < 2) begin : g_fixed
        assign start_of[gi] = (gi == 1) ? EP0_TX_START : EP0_RX_START;
        assign size_of[gi]  = EP0_BYTES;
      end else begin : g_cfg
        assign start_of[gi] = start_reg[gi];
        assign size_of[gi]  = (SIZE_UNIT << code_reg[gi][2:0]) << code_reg[gi][3];
      end
      assign hit_sel[gi]  = sel_reg == EW'(gi);
      assign inc_vec[gi]  = (sw_push && hit_sel[gi]) || (lk_push && link.rx_entry == EW'(gi));
      assign dec_vec[gi]  = (sw_pop && hit_sel[gi]) || (lk_pop && link.tx_entry == EW'(gi));
      assign clr_vec[gi]  = hit_sel[gi] && (flush_cmd || ack_cmd);
      assign done_vec[gi] = (link.rx_pkt_end && link.rx_entry == EW'(gi))
                            || (link.tx_done && link.tx_entry == EW'(gi));
      assign tok_vec[gi]  = want[gi] && scan_reg == EW'(gi);
      if (gi % 2 == 1) begin : g_tx
        assign want[gi]      = host_mode && !req_reg[gi] && pend_reg[gi];
        assign pend_set[gi]  = hit_sel[gi] && ((wr_cmd && wdata[CMD_SEND])
                               || (sw_push && hcfg_reg[gi].auto_send_on_full_payload
                               && cnt_reg[gi] + CW'(1) == CW'(maxp_reg[gi])));
        assign ready_clr[gi] = 1'b0;
        always_comb begin
          case (hcfg_reg[gi].dma_request_style)
            dma_per_byte:   dma_next[gi] = !pend_reg[gi] && cnt_reg[gi] < size_of[gi];
            dma_per_packet: dma_next[gi] = !pend_reg[gi] && cnt_reg[gi] == '0;
            default:        dma_next[gi] = 1'b0;
          endcase
        end
      end else begin : g_rx
        assign want[gi]      = host_mode && !req_reg[gi] && !ready_reg[gi]
                               && (due_reg[gi] || (hcfg_reg[gi].auto_in_token_request
                               && size_of[gi] - cnt_reg[gi] >= CW'(maxp_reg[gi])));
        assign pend_set[gi]  = 1'b0;
        assign ready_clr[gi] = clr_vec[gi]
                               || (hit_sel[gi] && wr_cmd && wdata[CMD_CLR_READY])
                               || (hcfg_reg[gi].auto_ready_flag_clear && sw_pop
                               && hit_sel[gi] && cnt_reg[gi] == CW'(1));
        always_comb begin
          case (hcfg_reg[gi].dma_request_style)
            dma_per_byte:   dma_next[gi] = cnt_reg[gi] != '0;
            dma_per_packet: dma_next[gi] = ready_reg[gi];
            default:        dma_next[gi] = 1'b0;
          endcase
        end
      end
      usbf_ep_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .sof      (link.sof),
        .nak      (link.nak && link.nak_entry == EW'(gi)),
        .clr      (done_vec[gi] || (hit_sel[gi] && flush_cmd)),
        .is_ep0   (gi < 2),
        .xfer     (hcfg_reg[gi].xfer),
        .interval (ival_reg[gi]),
        .poll     (poll[gi]),
        .timeout  (tmo[gi])
      );
    end
  endgenerate

  // ============================================================
  // Configuration registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_mode <= 1'b0;
      sel_reg   <= '0;
      for (int i = 0; i < NUM_ENT; i++) begin
        start_reg[i] <= START_RST;
        code_reg[i]  <= CODE_RST;
        hcfg_reg[i]  <= '0;
        maxp_reg[i]  <= MAXP_RST;
        ival_reg[i]  <= IVAL_RST;
      end
    end else if (wr_en) begin
      case (addr)
        OFF_CTRL: host_mode <= wdata[CTRL_HOST];
        OFF_SEL:  sel_reg <= wdata[EW-1:0];
        OFF_BUF: begin
          if (sel_reg[EW-1:1] != '0) begin
            start_reg[sel_reg] <= wdata[RAM_AW-1:0];
            code_reg[sel_reg]  <= wdata[BUF_CODE_LSB+3:BUF_CODE_LSB];
          end
        end
        OFF_HOST: hcfg_reg[sel_reg] <= usbf_hcfg_t'(wdata[$bits(usbf_hcfg_t)-1:0]);
        OFF_MAXP: maxp_reg[sel_reg] <= wdata[MPW-1:0];
        OFF_IVAL: ival_reg[sel_reg] <= wdata[IVW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // Buffer occupancy and pointers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        cnt_reg[i]  <= '0;
        wptr_reg[i] <= '0;
        rptr_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_ENT; i++) begin
        if (clr_vec[i]) begin
          cnt_reg[i]  <= '0;
          wptr_reg[i] <= '0;
          rptr_reg[i] <= '0;
        end else begin
          cnt_reg[i]  <= cnt_reg[i] + CW'(inc_vec[i]) - CW'(dec_vec[i]);
          wptr_reg[i] <= wptr_reg[i] + CW'(inc_vec[i]);
          rptr_reg[i] <= rptr_reg[i] + CW'(dec_vec[i]);
        end
      end
    end
  end

  // ============================================================
  // Shared buffer RAM.
  always_ff @(posedge clk) begin
    if (sw_push) begin
      mem[sw_addr] <= wdata[7:0];
    end
    if (lk_push) begin
      mem[lk_wr_addr] <= link.rx_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= '0;
    end else if (lk_pop) begin
      tx_data <= mem[lk_rd_addr];
    end
  end

  // ============================================================
  // Packet flags; a set wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg   <= '0;
      pend_reg    <= '0;
      tout_reg    <= '0;
      refused_reg <= '0;
      req_reg     <= '0;
      due_reg     <= '0;
    end else begin
      for (int i = 0; i < NUM_ENT; i++) begin
        if (ready_clr[i]) begin
          ready_reg[i] <= 1'b0;
        end
        if (link.rx_pkt_end && link.rx_entry == EW'(i)) begin
          ready_reg[i] <= 1'b1;
        end
        if (clr_vec[i] || (link.tx_done && link.tx_entry == EW'(i))) begin
          pend_reg[i] <= 1'b0;
        end
        if (pend_set[i]) begin
          pend_reg[i] <= 1'b1;
        end
        if (clr_vec[i] || (hit_sel[i] && wr_cmd && wdata[CMD_CLR_ERR])) begin
          tout_reg[i]    <= 1'b0;
          refused_reg[i] <= 1'b0;
        end
        if (tmo[i]) begin
          tout_reg[i] <= 1'b1;
        end
        if (hit_sel[i] && wr_en && addr == OFF_DATA && sel_tx && pend_reg[i]) begin
          refused_reg[i] <= 1'b1;
        end
        if (clr_vec[i] || done_vec[i] || (link.nak && link.nak_entry == EW'(i))) begin
          req_reg[i] <= 1'b0;
        end
        if (tok_vec[i]) begin
          req_reg[i] <= 1'b1;
        end
        if (clr_vec[i] || tok_vec[i]) begin
          due_reg[i] <= 1'b0;
        end
        if (poll[i] || (hit_sel[i] && wr_cmd && wdata[CMD_REQ_IN])) begin
          due_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Host token issue, one entry examined per cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_reg <= '0;
      token    <= '0;
    end else begin
      scan_reg        <= scan_reg + EW'(1);
      token.valid     <= want[scan_reg];
      token.is_in     <= scan_reg[0] == host_receive_dir;
      token.func_addr <= hcfg_reg[scan_reg].func_addr;
      token.remote_ep <= hcfg_reg[scan_reg].remote_endpoint_number;
      token.low_speed <= hcfg_reg[scan_reg].speed_sel_low;
      token.entry     <= scan_reg;
    end
  end

  // ============================================================
  // Frame number, link-facing flags and DMA requests.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg  <= '0;
      tx_pending <= '0;
      rx_ready   <= '0;
      dma_req    <= '0;
    end else begin
      if (link.sof) begin
        frame_reg <= link.frame;
      end
      tx_pending <= pend_set | (pend_reg & ~clr_vec);
      rx_ready   <= ready_reg;
      dma_req    <= dma_next;
    end
  end

  // ============================================================
  // Register read port, data one cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        OFF_CTRL:   rdata <= 32'(host_mode);
        OFF_SEL:    rdata <= 32'(sel_reg);
        OFF_BUF:    rdata <= {12'h000, code_reg[sel_reg], 6'h00, start_of[sel_reg]};
        OFF_HOST:   rdata <= 32'(hcfg_reg[sel_reg]);
        OFF_MAXP:   rdata <= 32'(maxp_reg[sel_reg]);
        OFF_IVAL:   rdata <= 32'(ival_reg[sel_reg]);
        OFF_DATA:   rdata <= sw_pop ? {24'h00_0000, mem[sw_addr]} : 32'h0000_0000;
        OFF_STATUS: rdata <= {12'h000, refused_reg[sel_reg], tout_reg[sel_reg],
                              pend_reg[sel_reg], ready_reg[sel_reg], 4'h0, cnt_reg[sel_reg]};
        OFF_FRAME:  rdata <= 32'(frame_reg);
        default:    rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// File: bench/usbf_checker_assertions.sv
// Port-level assertions for the endpoint buffer block.
module usbf_checker
  import usbf_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wdata,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire logic [31:0]        rdata,
  input wire usbf_link_t         link,
  input wire logic [7:0]         tx_data,
  input wire usbf_token_t        token,
  input wire logic [NUM_ENT-1:0] tx_pending,
  input wire logic [NUM_ENT-1:0] rx_ready,
  input wire logic               host_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [EW-1:0] sel_reg;
  // ============================================================
  // Entry selected by software.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sel_reg <= '0;
    else if (wr_en && addr == OFF_SEL) sel_reg <= wdata[EW-1:0];
  end
  // ============================================================
  // Properties.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmd(int b);
    wr_en && addr == OFF_CMD && wdata[b] && !link.rx_pkt_end;
  endsequence
  sequence s_sof_read;
    link.sof ##1 (rd_en && addr == OFF_FRAME && !link.sof);
  endsequence
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == '0)
    else $error("read data not idle");
  chk_frame_read: assert property (
    s_sof_read |=> rdata[FNW-1:0] == $past(link.frame, 2))
    else $error("frame number read back wrong");
  chk_ctrl_write: assert property (
    wr_en && addr == OFF_CTRL |=> host_mode == $past(wdata[CTRL_HOST]))
    else $error("host mode not taken from write");
  chk_token_host: assert property (token.valid |-> host_mode)
    else $error("token outside host mode");
  chk_tx_done: assert property (
    link.tx_done |-> ##2 !tx_pending[$past(link.tx_entry, 2)])
    else $error("pending not cleared after send");
  chk_rx_walk: assert property (
    link.rx_pkt_end && !link.rx_entry[0] |-> ##2 rx_ready[$past(link.rx_entry, 2)])
    else $error("ready flag not raised");
  chk_clr_ready: assert property (
    s_cmd(CMD_CLR_READY) |-> ##2 !rx_ready[$past(sel_reg, 2)])
    else $error("ready flag not cleared");
  chk_ack_free: assert property (
    s_cmd(CMD_ACK) ##0 host_mode |-> ##2 !rx_ready[$past(sel_reg, 2)])
    else $error("acknowledge did not release packet");
  chk_tx_hold: assert property (!link.tx_rd |=> $stable(tx_data))
    else $error("transmit byte changed without fetch");
endmodule

bind usbf_endpoint_buf usbf_checker u_chk (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .link, .tx_data, .token, .tx_pending, .rx_ready, .host_mode);

// File: bench/usbf_bus_model.sv
// Behavioural bus-side partner that drives the link pulses.
module usbf_bus_model
  import usbf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  output usbf_link_t      link
);
  timeunit 1ns;
  timeprecision 1ns;
  initial link = '0;
  task automatic sof(input logic [FNW-1:0] f);
    link.sof   <= 1'b1;
    link.frame <= f;
    @(posedge clk);
    link.sof   <= 1'b0;
    link.frame <= ~f;
  endtask
  task automatic rx_pkt(input logic [EW-1:0] e, input int n, input logic [7:0] d0);
    for (int i = 0; i < n; i++) begin
      link.rx_wr    <= 1'b1;
      link.rx_entry <= e;
      link.rx_data  <= d0 + 8'(i);
      @(posedge clk);
    end
    link.rx_wr      <= 1'b0;
    link.rx_data    <= ~d0;
    link.rx_pkt_end <= 1'b1;
    @(posedge clk);
    link.rx_pkt_end <= 1'b0;
  endtask
  task automatic fetch(input logic [EW-1:0] e, output logic [7:0] b);
    link.tx_rd    <= 1'b1;
    link.tx_entry <= e;
    @(posedge clk);
    link.tx_rd <= 1'b0;
    #1 b = tx_data;
    @(posedge clk);
  endtask
  task automatic done(input logic [EW-1:0] e);
    link.tx_done  <= 1'b1;
    link.tx_entry <= e;
    @(posedge clk);
    link.tx_done <= 1'b0;
  endtask
endmodule

// File: bench/usbf_endpoint_buf_tb.sv
// Self-checking testbench for the endpoint buffer block.
module usbf_endpoint_buf_tb
  import usbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  usbf_link_t  link;
  logic [7:0]  tx_data;
  usbf_token_t token;
  logic [7:0]  dma_req;
  int          errors = 0;
  int          tests_run = 0;
  always #25 clk = ~clk;
  usbf_endpoint_buf DUT (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .link,
    .tx_data, .token, .tx_pending(), .rx_ready(), .dma_req, .host_mode());
  usbf_bus_model bus (.clk, .tx_data, .link);
  // ============================================================
  // Bus access and checking.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ============================================================
  // Scenarios.
  task automatic t_buf();
    logic [31:0] v;
    logic [31:0] v0;
    wr(OFF_SEL, 32'h0000_0003);
    wr(OFF_BUF, 32'h0009_0040);
    rd(OFF_BUF, v);
    chk(v, 32'h0009_0040);
    wr(OFF_SEL, 32'h0000_0002);
    rd(OFF_BUF, v);
    chk(v, 32'h0000_0000);
    wr(OFF_SEL, 32'h0000_0000);
    rd(OFF_BUF, v0);
    wr(OFF_BUF, 32'h0009_0040);
    rd(OFF_BUF, v);
    chk(v0, 32'(EP0_RX_START));
    chk(v, 32'(EP0_RX_START));
    rd(8'hFC, v);
    chk(v, 32'h0000_0000);
  endtask
  task automatic t_frame();
    logic [31:0] v;
    bus.sof(11'h5A3);
    rd(OFF_FRAME, v);
    chk(v, 32'h0000_05A3);
  endtask
  task automatic t_rx();
    logic [31:0] v;
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_SEL, 32'h0000_0002);
    bus.rx_pkt(3'h2, 3, 8'hA0);
    @(posedge clk);
    rd(OFF_STATUS, v);
    chk(v, 32'h0001_0003);
    for (int i = 0; i < 3; i++) begin
      rd(OFF_DATA, v);
      chk(v, 32'(8'hA0 + 8'(i)));
    end
    rd(OFF_STATUS, v);
    chk(v, 32'h0001_0000);
    wr(OFF_CMD, 32'h0000_0004);
    rd(OFF_STATUS, v);
    chk(v, 32'h0000_0000);
    bus.rx_pkt(3'h2, 1, 8'h5C);
    wr(OFF_CMD, 32'h0000_0008);
    rd(OFF_STATUS, v);
    chk(v, 32'h0000_0001);
    wr(OFF_CMD, 32'h0000_0001);
    rd(OFF_STATUS, v);
    chk(v, 32'h0000_0000);
  endtask
  task automatic t_tx();
    logic [31:0] v;
    logic [7:0]  b;
    wr(OFF_SEL, 32'h0000_0003);
    wr(OFF_MAXP, 32'h0000_0002);
    wr(OFF_HOST, 32'h0001_0B35);
    wr(OFF_DATA, 32'h0000_0011);
    wr(OFF_DATA, 32'h0000_0022);
    tok_wait();
    chk(32'({token.is_in, token.func_addr, token.remote_ep}), 32'h0000_0356);
    chk(32'({token.remote_ep, token.low_speed, token.entry}), 32'h0000_006B);
    @(posedge clk);
    wr(OFF_DATA, 32'h0000_0033);
    rd(OFF_STATUS, v);
    chk(v, 32'h000A_0002);
    bus.fetch(3'h3, b);
    chk(32'(b), 32'h0000_0011);
    bus.done(3'h3);
    rd(OFF_STATUS, v);
    chk(32'(v[ST_PEND]), 32'h0000_0000);
  endtask
  task automatic tok_wait();
    #1;
    for (int i = 0; i < 40 && token.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(token.valid), 32'h0000_0001);
  endtask
  task automatic t_auto();
    logic [31:0] v;
    wr(OFF_SEL, 32'h0000_0004);
    wr(OFF_HOST, 32'h0006_4000);
    tok_wait();
    chk(32'({token.is_in, token.entry}), 32'h0000_000C);
    @(posedge clk);
    bus.rx_pkt(3'h4, 1, 8'h77);
    rd(OFF_STATUS, v);
    chk(v, 32'h0001_0001);
    #1 chk(32'(dma_req), 32'h0000_0010);
    @(posedge clk);
    rd(OFF_DATA, v);
    chk(v, 32'h0000_0077);
    rd(OFF_STATUS, v);
    chk(v, 32'h0000_0000);
  endtask
  task automatic t_poll();
    wr(OFF_SEL, 32'h0000_0002);
    wr(OFF_HOST, 32'h0000_3000);
    wr(OFF_IVAL, 32'h0000_0002);
    bus.sof(11'h001);
    @(posedge clk);
    bus.sof(11'h002);
    tok_wait();
    chk(32'({token.is_in, token.entry}), 32'h0000_000A);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_buf();
    t_frame();
    t_rx();
    t_tx();
    t_auto();
    t_poll();
    stop_test();
  end
endmodule
